// *** rtl/chdpc_map.svh ***
// Register map, reset values and field positions of the config bank.
// Assumes byte-wide registers behind an 8-bit register pointer.
`ifndef CHDPC_MAP_SVH
`define CHDPC_MAP_SVH
// Register offsets
`define CHDPC_OFS_DSP1 8'h6C
`define CHDPC_OFS_INEN 8'h73
`define CHDPC_OFS_SLOT 8'h74
`define CHDPC_OFS_PWR  8'h75
// Reset values
`define CHDPC_RST_DSP1 8'h40
`define CHDPC_RST_INEN 8'hC0
`define CHDPC_RST_SLOT 8'h00
`define CHDPC_RST_PWR  8'h00
// Writable bits; the low nibbles are read-only
`define CHDPC_MSK_INEN 8'hF0
`define CHDPC_MSK_SLOT 8'hF0
// Processing config fields
`define CHDPC_BIT_GANG   7
`define CHDPC_BQ_HI      6
`define CHDPC_BQ_LO      5
`define CHDPC_BIT_NOSOFT 4
// Per-channel enable field, channel one at the top bit
`define CHDPC_EN_HI 7
// Power config fields
`define CHDPC_BIT_BIAS 7
`define CHDPC_BIT_ADC  6
`define CHDPC_BIT_PLL  5
`define CHDPC_BIT_LIVE 4
`define CHDPC_SPAN_HI  3
`define CHDPC_SPAN_LO  2
`define CHDPC_BIT_VAD  0
`define CHDPC_SPAN_ALL 2'h1
// Channels that switch live in the narrow span
`define CHDPC_NARROW 2
// Serial control port; the bus address is an arbitrary choice
`define CHDPC_I2C_ADDR 7'h4C
`define CHDPC_BYTE_BITS 4'h8
`endif

// *** rtl/chdpc_pkg.sv ***
// Types shared by the config bank and its control port.
// Assumes the map header supplies all numeric constants.
package chdpc_pkg;
  // One register write from the control port
  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } chdpc_wr_t;
  // Device-wide controls
  typedef struct packed {
    logic       bias;
    logic       synth;
    logic       vad;
    logic       soft_step;
    logic [2:0] biquad;
  } chdpc_ctl_t;
  // Control port byte engine
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_addr = 3'h1,
    st_ack  = 3'h3,
    st_wr   = 3'h2,
    st_rd   = 3'h6,
    st_rack = 3'h7
  } chdpc_i2c_st_t;
endpackage

// *** rtl/chdpc_i2c.sv ***
// Two-wire serial control port slave with auto-incrementing pointer.
// Assumes mclk is far faster than the serial clock; pins are async.
`timescale 1ns/1ps
`include "chdpc_map.svh"
module chdpc_i2c (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 srst,
  // Serial pins, data is open drain
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  // Register side
  output chdpc_pkg::chdpc_wr_t      wr,
  output logic [7:0]                rd_addr,
  input  wire logic [7:0]           rd_data
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync_r;  // Two-stage sync
  logic [1:0] sda_sync_r;  // Two-stage sync
  logic       scl_d_r;     // Delayed copy for edges
  logic       sda_d_r;     // Delayed copy for edges

  // Idle bus is high, so sync resets high
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  logic scl, sda, rise, fall, start, stop;
  assign scl   = scl_sync_r[1];
  assign sda   = sda_sync_r[1];
  assign rise  = scl & ~scl_d_r;
  assign fall  = ~scl & scl_d_r;
  // Data edges while clock high frame a transfer
  assign start = scl & scl_d_r & ~sda & sda_d_r;
  assign stop  = scl & scl_d_r & sda & ~sda_d_r;

  // ----------------------------------------
  // Byte engine
  // ----------------------------------------
  chdpc_pkg::chdpc_i2c_st_t st_r;  // Engine state
  logic [3:0]               cnt_r; // Bit count
  logic [7:0]               sh_r;  // Shift register
  logic [7:0]               ptr_r; // Register pointer
  logic                     pok_r; // Pointer byte seen
  logic                     rw_r;  // Read transfer
  logic                     oe_r;  // Pulling data low
  chdpc_pkg::chdpc_wr_t     wr_r;  // Write pulse

  // Stop and start override any byte in flight
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_r  <= chdpc_pkg::st_idle;
      cnt_r <= 4'h0;
      sh_r  <= 8'h00;
      ptr_r <= 8'h00;
      pok_r <= 1'b0;
      rw_r  <= 1'b0;
      oe_r  <= 1'b0;
      wr_r  <= '0;
    end else begin
      wr_r.stb <= 1'b0;
      if (stop) begin
        st_r <= chdpc_pkg::st_idle;
        oe_r <= 1'b0;
      end else if (start) begin
        // Pointer survives a repeated start for reads
        st_r  <= chdpc_pkg::st_addr;
        cnt_r <= 4'h0;
        pok_r <= 1'b0;
        oe_r  <= 1'b0;
      end else begin
        case (st_r)
          chdpc_pkg::st_addr, chdpc_pkg::st_wr: begin
            if (rise) begin
              sh_r  <= {sh_r[6:0], sda};
              cnt_r <= cnt_r + 4'h1;
            end else if (fall && cnt_r == `CHDPC_BYTE_BITS) begin
              cnt_r <= 4'h0;
              if (st_r == chdpc_pkg::st_addr) begin
                // Foreign address: stay off the bus
                if (sh_r[7:1] == `CHDPC_I2C_ADDR) begin
                  st_r <= chdpc_pkg::st_ack;
                  oe_r <= 1'b1;
                  rw_r <= sh_r[0];
                end else begin
                  st_r <= chdpc_pkg::st_idle;
                end
              end else begin
                st_r <= chdpc_pkg::st_ack;
                oe_r <= 1'b1;
                if (pok_r) begin
                  wr_r.stb  <= 1'b1;
                  wr_r.addr <= ptr_r;
                  wr_r.data <= sh_r;
                  ptr_r     <= ptr_r + 8'h01;
                end else begin
                  ptr_r <= sh_r;
                  pok_r <= 1'b1;
                end
              end
            end
          end
          chdpc_pkg::st_ack: begin
            if (fall) begin
              if (rw_r) begin
                st_r  <= chdpc_pkg::st_rd;
                sh_r  <= rd_data;
                oe_r  <= ~rd_data[7];
                cnt_r <= 4'h1;
              end else begin
                st_r  <= chdpc_pkg::st_wr;
                oe_r  <= 1'b0;
                cnt_r <= 4'h0;
              end
            end
          end
          chdpc_pkg::st_rd: begin
            if (fall) begin
              if (cnt_r == `CHDPC_BYTE_BITS) begin
                st_r <= chdpc_pkg::st_rack;
                oe_r <= 1'b0;
              end else begin
                sh_r  <= {sh_r[6:0], 1'b0};
                oe_r  <= ~sh_r[6];
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          chdpc_pkg::st_rack: begin
            // Master nack ends the read
            if (rise) begin
              if (sda) begin
                st_r <= chdpc_pkg::st_idle;
              end else begin
                ptr_r <= ptr_r + 8'h01;
              end
            end else if (fall) begin
              st_r  <= chdpc_pkg::st_rd;
              sh_r  <= rd_data;
              oe_r  <= ~rd_data[7];
              cnt_r <= 4'h1;
            end
          end
          default: begin
            st_r <= chdpc_pkg::st_idle;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = oe_r;
  assign wr      = wr_r;
  assign rd_addr = ptr_r;
endmodule

// *** rtl/chdpc_regs.sv ***
// Channel processing and power configuration bank of a four-channel
// converter, written over the serial control port.
// Assumes volume and slot data come from logic on mclk.
//
// What this block does
// [R1] Gang on: all channels use channel-one volume
// [R2] Biquad field selects zero to three stages
// [R3] Soft-step ramps unless its disable bit set
// [R4] Software writes reserved bits only at reset
// [R5] Channels one, two enable; reset enabled
// [R6] Channels three, four enable; reset disabled
// [R7] Slot enable drives output slot, else tri-state
// [R8] Slot enable register resets to zero
// [R9] Power config register resets to zero
// [R10] Channel power bit powers enabled channels
// [R11] Without live switching, no change while recording
// [R12] Live span: channels one-two, or all four
// [R13] Bias, PLL power and voice detect bits
// [R14] Read-only reserved bits read zero, ignore writes
`timescale 1ns/1ps
`include "chdpc_map.svh"
module chdpc_regs (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 srst,
  // Serial control pins
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  // Volume path
  input  wire logic [3:0][7:0]      per_channel_volume,
  output logic [3:0][7:0]           applied_volume,
  // Serial audio output slot
  input  wire logic [1:0]           slot_index,
  input  wire logic                 slot_bit,
  output logic                      sdout_out,
  output logic                      sdout_oe,
  // Channel controls
  output logic [3:0]                input_on,
  output logic [3:0]                slot_drive,
  output logic [3:0]                ch_power,
  output chdpc_pkg::chdpc_ctl_t     ctl
);
  // ----------------------------------------
  // Control port
  // ----------------------------------------
  chdpc_pkg::chdpc_wr_t wr;      // Write pulse
  logic [7:0]           rd_addr; // Read pointer
  logic [7:0]           rd_data; // Read value

  chdpc_i2c u_port (
    .mclk    (mclk),
    .srst    (srst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr      (wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] dsp1_r; // Processing config
  logic [7:0] inen_r; // Input enables
  logic [7:0] slot_r; // Output slot enables
  logic [7:0] pwr_r;  // Power config

  // Read-only nibbles are masked so they stay zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      dsp1_r <= `CHDPC_RST_DSP1; // R2
      inen_r <= `CHDPC_RST_INEN; // R5 R6
      slot_r <= `CHDPC_RST_SLOT; // R8
      pwr_r  <= `CHDPC_RST_PWR;  // R9
    end else if (wr.stb) begin
      if (wr.addr == `CHDPC_OFS_DSP1) begin
        dsp1_r <= wr.data;
      end else if (wr.addr == `CHDPC_OFS_INEN) begin
        inen_r <= wr.data & `CHDPC_MSK_INEN; // R14
      end else if (wr.addr == `CHDPC_OFS_SLOT) begin
        slot_r <= wr.data & `CHDPC_MSK_SLOT; // R14
      end else if (wr.addr == `CHDPC_OFS_PWR) begin
        pwr_r <= wr.data;
      end
    end
  end

  // Read decode; unmapped pointers read zero
  always_comb begin
    if (rd_addr == `CHDPC_OFS_DSP1) begin
      rd_data = dsp1_r;
    end else if (rd_addr == `CHDPC_OFS_INEN) begin
      rd_data = inen_r;
    end else if (rd_addr == `CHDPC_OFS_SLOT) begin
      rd_data = slot_r;
    end else if (rd_addr == `CHDPC_OFS_PWR) begin
      rd_data = pwr_r;
    end else begin
      rd_data = 8'h00;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic       gang;    // Volume ganged
  logic [1:0] bq_cnt;  // Biquad stages
  logic       live;    // Live channel switching
  logic [1:0] span;    // Live switching span
  logic       adc_on;  // Channel power bit
  logic       any_on;  // Some channel recording

  assign gang   = dsp1_r[`CHDPC_BIT_GANG];
  assign bq_cnt = dsp1_r[`CHDPC_BQ_HI:`CHDPC_BQ_LO];
  assign live   = pwr_r[`CHDPC_BIT_LIVE];
  assign span   = pwr_r[`CHDPC_SPAN_HI:`CHDPC_SPAN_LO];
  assign adc_on = pwr_r[`CHDPC_BIT_ADC];
  assign any_on = |ch_power;

  // ----------------------------------------
  // Per-channel logic
  // ----------------------------------------
  logic [3:0][7:0] vol_nxt;  // Next applied volume
  logic [3:0]      pwr_nxt;  // Next channel power
  logic [3:0]      in_span;  // May switch live

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_ch
      assign input_on[k]   = inen_r[`CHDPC_EN_HI - k];  // R5 R6
      assign slot_drive[k] = slot_r[`CHDPC_EN_HI - k];
      // Ganged channels follow channel one even if it is off
      assign vol_nxt[k] = gang ? per_channel_volume[0]
                               : per_channel_volume[k]; // R1
      // Reserved span codes act as the narrow span
      assign in_span[k] = (k < `CHDPC_NARROW) ||
                          (span == `CHDPC_SPAN_ALL);    // R12
      // Clearing power wins; otherwise change only when allowed
      assign pwr_nxt[k] = !adc_on ? 1'b0 :              // R10
                          (!any_on || (live && in_span[k])) ?
                          input_on[k] : ch_power[k];    // R11
    end
  endgenerate

  // Volume and channel power state
  always_ff @(posedge mclk) begin
    if (srst) begin
      applied_volume <= '0;
      ch_power       <= 4'h0;
    end else begin
      applied_volume <= vol_nxt;
      ch_power       <= pwr_nxt;
    end
  end

  // ----------------------------------------
  // Device-wide controls
  // ----------------------------------------
  // Thermometer of stages; zero turns every biquad off
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctl <= '0;
    end else begin
      ctl.bias      <= pwr_r[`CHDPC_BIT_BIAS];     // R13
      ctl.synth     <= pwr_r[`CHDPC_BIT_PLL];      // R13
      ctl.vad       <= pwr_r[`CHDPC_BIT_VAD];      // R13
      ctl.soft_step <= ~dsp1_r[`CHDPC_BIT_NOSOFT]; // R3
      ctl.biquad    <= {bq_cnt == 2'h3, bq_cnt[1], |bq_cnt}; // R2
    end
  end

  // Output slot pin; one cycle behind the slot index
  always_ff @(posedge mclk) begin
    if (srst) begin
      sdout_out <= 1'b0;
      sdout_oe  <= 1'b0;
    end else begin
      sdout_oe  <= slot_drive[slot_index];            // R7
      sdout_out <= slot_bit & slot_drive[slot_index];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_pwr_write;
    wr.stb && wr.addr == `CHDPC_OFS_PWR;
  endsequence

  property p_gang;
    gang |=> applied_volume[3] == $past(per_channel_volume[0]);
  endproperty
  a_gang: assert property (p_gang) else $error("gang volume wrong"); // R1

  property p_biquad;
    bq_cnt == 2'h0 |=> ctl.biquad == 3'h0;
  endproperty
  a_biquad: assert property (p_biquad) else $error("biquad not off"); // R2

  property p_soft;
    dsp1_r[`CHDPC_BIT_NOSOFT] |=> !ctl.soft_step;
  endproperty
  a_soft: assert property (p_soft) else $error("soft step on"); // R3

  property p_in_rst;
    $fell(srst) |-> input_on == 4'h3 && slot_drive == 4'h0;
  endproperty
  a_in_rst: assert property (disable iff (1'b0) p_in_rst)
    else $error("enable reset wrong"); // R6

  property p_slot;
    !slot_drive[slot_index] |=> !sdout_oe;
  endproperty
  a_slot: assert property (p_slot) else $error("slot driven"); // R7

  property p_pwr_off;
    !adc_on |=> ch_power == 4'h0 ##1 (ch_power == 4'h0 || adc_on);
  endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("channel on"); // R10

  property p_hold;
    adc_on && !live && any_on |=> ch_power == $past(ch_power);
  endproperty
  a_hold: assert property (p_hold) else $error("power changed"); // R11

  property p_span;
    adc_on && live && span != `CHDPC_SPAN_ALL && any_on
      |=> ch_power[3:2] == $past(ch_power[3:2]);
  endproperty
  a_span: assert property (p_span) else $error("span broken"); // R12

  property p_bias;
    s_pwr_write ##0 wr.data[`CHDPC_BIT_BIAS] ##1 !wr.stb |=> ctl.bias;
  endproperty
  a_bias: assert property (p_bias) else $error("bias not on"); // R13

  property p_rsvd;
    inen_r[3:0] == 4'h0 && slot_r[3:0] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set"); // R14
endmodule

// *** testbench/chdpc_host.sv ***
// Host model: two-wire control port master with open-drain data.
// Assumes the bench resolves the data wire from both pull-downs.
`timescale 1ns/1ps
module chdpc_host (
  // Clock
  input  wire logic mclk,
  // Serial pins
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  // Third of a bit in mclk cycles; keeps well clear of the 2-flop syncs
  localparam int unsigned QTR = 8;

  // Idle bus: clock high, data released
  initial begin
    scl     <= 1'b1;
    sda_low <= 1'b0;
  end

  // Wait one third of a bit
  task automatic hold();
    repeat (QTR) @(posedge mclk);
  endtask

  // ----------------------------------------
  // Frame primitives
  // ----------------------------------------
  // Start or repeated start; ends with clock low
  // Begins on a clock edge so the pins always move with mclk
  task automatic start();
    @(posedge mclk);
    sda_low <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b0;
    hold();
  endtask

  // Stop; leaves the bus idle
  task automatic stop();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b0;
    hold();
  endtask

  // Eight data bits then the ninth; a 1 releases the wire
  task automatic xfer(input logic [7:0] tx, input logic ninth,
                      output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    sh = {tx, ninth};
    for (int i = 8; i >= 0; i--) begin
      sda_low <= ~sh[i];
      hold();
      scl <= 1'b1;
      hold();
      sh[i] = sda;
      scl <= 1'b0;
      hold();
    end
    rx  = sh[8:1];
    ack = ~sh[0];
  endtask
endmodule

// *** testbench/tb_channel_dsp_power_config.sv ***
// Self-checking bench for the channel processing and power config bank.
// Assumes the host model and the register map header are on the path.
`timescale 1ns/1ps
`include "chdpc_map.svh"
module tb_channel_dsp_power_config;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  mclk;      // Device clock
  logic                  srst;      // Sync reset
  wire logic             scl;       // Serial clock from host
  wire logic             sda_low;   // Host pulls data low
  wire logic             sda;       // Resolved data wire
  logic                  sda_dev;   // Level the device drives
  logic                  sda_oe;    // Device pulls data low
  logic [3:0][7:0]       vol_in;    // Volume per channel
  logic [3:0][7:0]       vol_used;  // Volume in use
  logic [1:0]            slot_idx;  // Current output slot
  logic                  slot_bit;  // Slot data bit
  logic                  sdout_out;
  logic                  sdout_oe;
  logic [3:0]            input_on;
  logic [3:0]            slot_drive;
  logic [3:0]            ch_power;
  chdpc_pkg::chdpc_ctl_t ctl;
  int                    err_total;
  int                    cmp_count;
  logic                  ack;
  logic [7:0]            rx;
  localparam logic [7:0] WR_ADDR = {`CHDPC_I2C_ADDR, 1'b0};
  localparam logic [7:0] RD_ADDR = {`CHDPC_I2C_ADDR, 1'b1};

  // Open drain with pull-up: low if the host pulls or the device drives low
  assign sda = ~sda_low & (sda_oe ? sda_dev : 1'b1);

  // 40 MHz clock
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  chdpc_host host (
    .mclk    (mclk),
    .scl     (scl),
    .sda_low (sda_low),
    .sda     (sda)
  );

  chdpc_regs uut (
    .mclk               (mclk),
    .srst               (srst),
    .scl_in             (scl),
    .sda_in             (sda),
    .sda_out            (sda_dev),
    .sda_oe             (sda_oe),
    .per_channel_volume (vol_in),
    .applied_volume     (vol_used),
    .slot_index         (slot_idx),
    .slot_bit           (slot_bit),
    .sdout_out          (sdout_out),
    .sdout_oe           (sdout_oe),
    .input_on           (input_on),
    .slot_drive         (slot_drive),
    .ch_power           (ch_power),
    .ctl                (ctl)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compare and count; four-state equality so unknowns fail
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register write: address, pointer, one data byte
  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
    host.start();
    host.xfer(WR_ADDR, 1'b1, rx, ack);
    host.xfer(ptr, 1'b1, rx, ack);
    host.xfer(dat, 1'b1, rx, ack);
    host.stop();
  endtask

  // Register read via repeated start, master ends with no-ack
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    host.start();
    host.xfer(WR_ADDR, 1'b1, rx, ack);
    host.xfer(ptr, 1'b1, rx, ack);
    host.start();
    host.xfer(RD_ADDR, 1'b1, rx, ack);
    host.xfer(8'hFF, 1'b1, rx, ack);
    host.stop();
    chk(rx, exp);
  endtask

  // Counts, verdict, end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    cmp_count = 0;
    srst      <= 1'b1;
    vol_in    <= {8'h44, 8'h33, 8'h22, 8'h11};
    slot_idx  <= 2'h0;
    slot_bit  <= 1'b0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk(32'(ctl), 32'h0B);
    chk(input_on, 4'h3);
    chk(slot_drive, 4'h0);
    chk(ch_power, 4'h0);
    rd(`CHDPC_OFS_DSP1, 8'h40);
    rd(`CHDPC_OFS_INEN, 8'hC0);
    rd(`CHDPC_OFS_SLOT, 8'h00);
    rd(`CHDPC_OFS_PWR, 8'h00);
    // Every stage count, reserved low nibble kept at zero
    for (int n = 0; n < 4; n++) begin
      wr(`CHDPC_OFS_DSP1, 8'(n << 5));
      chk(32'(ctl.biquad), 32'((1 << n) - 1));
    end
    chk(vol_used, {8'h44, 8'h33, 8'h22, 8'h11});
    // Gang on, soft-step off
    wr(`CHDPC_OFS_DSP1, 8'h90);
    chk(ctl.soft_step, 1'b0);
    chk(vol_used, {4{8'h11}});
    // Read-only low nibbles read zero; software only ever writes them as zero
    wr(`CHDPC_OFS_INEN, 8'hF0);
    chk(input_on, 4'hF);
    rd(`CHDPC_OFS_INEN, 8'hF0);
    wr(`CHDPC_OFS_SLOT, 8'hA0);
    rd(`CHDPC_OFS_SLOT, 8'hA0);
    chk(slot_drive, 4'h5);
    // Unmapped pointer must not disturb the bank
    wr(8'h70, 8'h00);
    rd(`CHDPC_OFS_INEN, 8'hF0);
    // Slots one and three driven, two and four floating
    // Data bit low on slot three shows the pin follows the bit
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      slot_idx <= 2'(i);
      slot_bit <= ~i[1];
      @(posedge mclk);
      #1;
      chk({sdout_oe, sdout_out}, {~i[0], ~i[0] & ~i[1]});
    end
    // Bias, synth, channels and voice detect on
    wr(`CHDPC_OFS_PWR, 8'hE1);
    chk(32'(ctl), 32'h70);
    chk(ch_power, 4'hF);
    // No live switching: recording channels hold
    wr(`CHDPC_OFS_INEN, 8'h80);
    chk(ch_power, 4'hF);
    // Live switching, narrow span: only one and two follow
    wr(`CHDPC_OFS_PWR, 8'hF1);
    chk(ch_power, 4'hD);
    // Wide span: all four follow
    wr(`CHDPC_OFS_PWR, 8'hF5);
    chk(ch_power, 4'h1);
    rd(`CHDPC_OFS_PWR, 8'hF5);
    // Everything off
    wr(`CHDPC_OFS_PWR, 8'h00);
    chk(ch_power, 4'h0);
    chk(32'(ctl), 32'h00);
    wrap_up();
  end

  // Watchdog, about three and a half times the expected run
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    wrap_up();
  end
endmodule
